//--- addr_mode_decoder.sv
// instruction length and effective address decoder with memory fetch sequencer
`timescale 1ns/1ps
`default_nettype none
`include "addr_decoder_cfg.svh"

module addr_mode_decoder
   import addr_decoder_pkg::*;
(
   input wire logic REF_CLK, // core clock, 200 MHz
   input wire logic RST_N, // asynchronous reset, active low
   input wire logic START, // pulse: decode the instruction at START_PC
   input wire logic [15:0] START_PC, // address of the first instruction byte
   input wire logic [7:0] X_REG, // X index register
   input wire logic [7:0] Y_REG, // Y index register
   output logic MEM_RD, // pulse: read request to program/data memory
   output logic [15:0] MEM_ADDR, // read address, held until acknowledge
   input wire logic [7:0] MEM_RDATA, // read data, valid with MEM_ACK
   input wire logic MEM_ACK, // pulse: read data valid
   output logic BUSY, // decode in progress
   output logic DONE, // pulse: RESULT valid
   output result_t RESULT, // decoded instruction, held until next DONE
   output logic [15:0] NEXT_PC, // address after the decoded instruction
   output logic ILLEGAL_RST, // pulse: undefined code, reset request
   output logic HALT_REQ, // pulse: stop oscillator request
   output logic WAIT_REQ // pulse: low power wait request
);

   typedef enum logic [2:0] {
      S_IDLE,
      S_OPC,
      S_DEC,
      S_OPS,
      S_PTR,
      S_FIN
   } state_t;

   function automatic logic is_prefix(input logic [7:0] b);
      is_prefix = (b == `Y_SUBSTITUTE_PREFIX) || (b == `Y_INDIRECT_INDEXED_PREFIX)
         || (b == `INDIRECT_FORM_PREFIX);
   endfunction : is_prefix

   state_t state;
   logic [15:0] pc;
   logic [2:0] len;
   logic has_prefix;
   logic [7:0] prefix;
   logic [7:0] opcode;
   logic [7:0] b1;
   logic [7:0] b2;
   logic [7:0] p0;
   logic [7:0] p1;
   logic [1:0] cnt;
   logic wait_ack;
   decode_t dec;
   decode_t dreg;
   logic [15:0] ea;
   logic [15:0] target;
   logic [15:0] next_addr;
   logic issue;
   logic got;

   // combinational classification of the registered opcode and prefix
   opcode_classifier u_classifier (
      .has_prefix(has_prefix),
      .prefix(prefix),
      .opcode(opcode),
      .dec(dec)
   );

   // address arithmetic on the collected bytes
   ea_unit u_ea (
      .mode(dreg.mode),
      .use_y(dreg.use_y),
      .x_val(X_REG),
      .y_val(Y_REG),
      .b1(b1),
      .b2(b2),
      .p0(p0),
      .p1(p1),
      .pc(pc),
      .ea(ea),
      .target(target)
   );

   // a read completes when an acknowledge arrives for the outstanding request
   assign got = wait_ack && MEM_ACK && !MEM_RD; // an answer in the request cycle is stale

   // decide whether a new read goes out next cycle and where it points
   always_comb begin
      issue = 1'b0;
      next_addr = MEM_ADDR;
      case (state)
         S_IDLE: begin
            issue = START;
            next_addr = START_PC;
         end
         S_OPC: begin
            issue = got && is_prefix(MEM_RDATA) && !has_prefix;
            next_addr = pc + 16'h0001;
         end
         S_DEC: begin
            issue = dec.legal && (dec.n_ops != 2'd0);
            next_addr = pc;
         end
         S_OPS: begin
            if (got && ({1'b0, cnt} + 3'd1 < {1'b0, dreg.n_ops})) begin
               issue = 1'b1;
               next_addr = pc + 16'h0001;
            end else if (got && dreg.n_ptr != 2'd0) begin
               issue = 1'b1; // pointer location is the page-zero address held in the first byte after the opcode
               next_addr = {`PAGE_ZERO_HI, (cnt == 2'd0) ? MEM_RDATA : b1};
            end
         end
         S_PTR: begin
            issue = got && ({1'b0, cnt} + 3'd1 < {1'b0, dreg.n_ptr});
            next_addr = {`PAGE_ZERO_HI, MEM_ADDR[7:0] + 8'h01};
         end
         default: begin
            issue = 1'b0;
            next_addr = MEM_ADDR;
         end
      endcase
   end

   // sequencer state
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= S_IDLE;
      end else begin
         case (state)
            S_IDLE: begin
               if (START)
                  state <= S_OPC;
            end
            S_OPC: begin
               if (got && !(is_prefix(MEM_RDATA) && !has_prefix))
                  state <= S_DEC;
            end
            S_DEC: begin
               if (!dec.legal)
                  state <= S_IDLE;
               else if (dec.n_ops != 2'd0)
                  state <= S_OPS;
               else
                  state <= S_FIN;
            end
            S_OPS: begin
               if (got && {1'b0, cnt} + 3'd1 >= {1'b0, dreg.n_ops})
                  state <= (dreg.n_ptr != 2'd0) ? S_PTR : S_FIN;
            end
            S_PTR: begin
               if (got && {1'b0, cnt} + 3'd1 >= {1'b0, dreg.n_ptr})
                  state <= S_FIN;
            end
            S_FIN: state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // memory request port
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         MEM_RD <= 1'b0;
         MEM_ADDR <= `RESET_PC;
         wait_ack <= 1'b0;
      end else begin
         MEM_RD <= issue;
         if (issue)
            MEM_ADDR <= next_addr;
         if (issue)
            wait_ack <= 1'b1;
         else if (MEM_ACK)
            wait_ack <= 1'b0;
      end
   end

   // program counter and length count over prefix, opcode and operand bytes
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pc <= `RESET_PC;
         len <= `RESET_LEN;
      end else if (state == S_IDLE && START) begin
         pc <= START_PC;
         len <= `RESET_LEN;
      end else if (got && (state == S_OPC || state == S_OPS)) begin
         pc <= pc + 16'h0001;
         len <= len + 3'd1;
      end
   end

   // prefix and opcode capture
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         has_prefix <= 1'b0;
         prefix <= `RESET_BYTE;
         opcode <= `RESET_BYTE;
      end else if (state == S_IDLE && START) begin
         has_prefix <= 1'b0;
      end else if (state == S_OPC && got) begin
         if (is_prefix(MEM_RDATA) && !has_prefix) begin
            has_prefix <= 1'b1;
            prefix <= MEM_RDATA;
         end else begin
            opcode <= MEM_RDATA;
         end
      end
   end

   // classification held for the rest of the instruction
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N)
         dreg <= '0;
      else if (state == S_DEC)
         dreg <= dec;
   end

   // operand and pointer bytes, first byte fetched is the high byte of a word
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         b1 <= `RESET_BYTE;
         b2 <= `RESET_BYTE;
         p0 <= `RESET_BYTE;
         p1 <= `RESET_BYTE;
         cnt <= 2'd0;
      end else if (state == S_DEC) begin
         cnt <= 2'd0;
      end else if (got && state == S_OPS) begin
         if (cnt == 2'd0)
            b1 <= MEM_RDATA;
         else
            b2 <= MEM_RDATA;
         cnt <= ({1'b0, cnt} + 3'd1 >= {1'b0, dreg.n_ops}) ? 2'd0 : cnt + 2'd1;
      end else if (got && state == S_PTR) begin
         if (cnt == 2'd0)
            p0 <= MEM_RDATA;
         else
            p1 <= MEM_RDATA;
         cnt <= cnt + 2'd1;
      end
   end

   // result, next pc and completion pulse
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         DONE <= 1'b0;
         RESULT <= '0;
         NEXT_PC <= `RESET_PC;
      end else begin
         DONE <= (state == S_FIN);
         if (state == S_FIN) begin
            RESULT.mode <= dreg.mode;
            RESULT.length <= len;
            RESULT.ea <= ea;
            RESULT.operand <= b1;
            RESULT.target <= target;
            RESULT.use_y <= dreg.use_y;
            RESULT.combo_bad <= dreg.combo_bad;
            NEXT_PC <= pc;
         end
      end
   end

   // illegal-code reset and power requests
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ILLEGAL_RST <= 1'b0;
         HALT_REQ <= 1'b0;
         WAIT_REQ <= 1'b0;
      end else begin
         ILLEGAL_RST <= (state == S_DEC) && !dec.legal;
         HALT_REQ <= (state == S_FIN) && dreg.halt;
         WAIT_REQ <= (state == S_FIN) && dreg.wait_for_interrupt_op;
      end
   end

   // busy from start acceptance until completion or illegal-code abort
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N)
         BUSY <= 1'b0;
      else if (state == S_IDLE && START)
         BUSY <= 1'b1;
      else if (state == S_FIN || (state == S_DEC && !dec.legal))
         BUSY <= 1'b0;
   end

endmodule : addr_mode_decoder
`default_nettype wire

//--- addr_decoder_cfg.svh
// constants for the addressing-mode decoder: prefix codes, special opcodes, reset values
`ifndef ADDR_DECODER_CFG_SVH
`define ADDR_DECODER_CFG_SVH

// prefix byte values
`define Y_SUBSTITUTE_PREFIX 8'h90
`define Y_INDIRECT_INDEXED_PREFIX 8'h91
`define INDIRECT_FORM_PREFIX 8'h92

// single-byte power opcodes (inherent class)
`define HALT_OPCODE 8'h8e
`define WAIT_FOR_INTERRUPT_OPCODE 8'h8f

// opcodes outside the high-nibble pattern
`define MUL_OPCODE 8'h42
`define RELATIVE_CALL_OPCODE 8'had

// page-zero high byte for short addresses and pointer locations
`define PAGE_ZERO_HI 8'h00

// reset values
`define RESET_PC 16'h0000
`define RESET_BYTE 8'h00
`define RESET_LEN 3'h0

`endif

//--- addr_decoder_pkg.sv
// types shared by the addressing-mode decoder modules
`default_nettype none
package addr_decoder_pkg;

   // addressing modes after any prefix has been applied
   typedef enum logic [3:0] {
      MODE_INHERENT,
      MODE_IMMEDIATE,
      MODE_DIR_SHORT,
      MODE_DIR_LONG,
      MODE_IDX_NONE,
      MODE_IDX_SHORT,
      MODE_IDX_LONG,
      MODE_IND_SHORT,
      MODE_IND_LONG,
      MODE_IND_IDX_SHORT,
      MODE_IND_IDX_LONG,
      MODE_REL_DIRECT,
      MODE_REL_INDIRECT,
      MODE_BIT_DIRECT,
      MODE_BIT_REL,
      MODE_BIT_REL_IND
   } mode_t;

   // result of classifying one opcode with its prefix
   typedef struct packed {
      mode_t mode;
      logic [1:0] n_ops;      // bytes after the opcode
      logic [1:0] n_ptr;      // pointer bytes read at the pointer location
      logic use_y;
      logic legal;
      logic combo_bad;
      logic halt;
      logic wait_for_interrupt_op;
   } decode_t;

   // finished decode handed to the execution side
   typedef struct packed {
      mode_t mode;
      logic [2:0] length;
      logic [15:0] ea;
      logic [7:0] operand;
      logic [15:0] target;
      logic use_y;
      logic combo_bad;
   } result_t;

endpackage : addr_decoder_pkg
`default_nettype wire

//--- opcode_classifier.sv
// opcode classifier: mode, operand and pointer byte counts, legality, prefix effects
`timescale 1ns/1ps
`default_nettype none
`include "addr_decoder_cfg.svh"

module opcode_classifier
   import addr_decoder_pkg::*;
(
   input wire logic has_prefix, // a prefix byte preceded the opcode
   input wire logic [7:0] prefix, // that prefix byte
   input wire logic [7:0] opcode, // opcode byte
   output decode_t dec // classification
);

   // codes that are neither an opcode nor a prefix
   function automatic logic is_undefined(input logic [7:0] op);
      logic [3:0] lo;
      lo = op[3:0];
      is_undefined = 1'b0;
      case (op[7:4])
         4'h3, 4'h4, 4'h6, 4'h7: begin
            if ((lo == 4'h1 || lo == 4'h2 || lo == 4'h5 || lo == 4'hb) && op != `MUL_OPCODE)
               is_undefined = 1'b1;
         end
         4'h5: is_undefined = (lo == 4'h1 || lo == 4'h2 || lo == 4'h5 || lo == 4'hb);
         4'h8: is_undefined = (lo == 4'h2 || lo == 4'hb || lo == 4'hc || lo == 4'hd);
         4'ha: is_undefined = (lo == 4'h7 || lo == 4'hc);
         default: is_undefined = 1'b0;
      endcase
   endfunction : is_undefined

   function automatic logic is_prefix(input logic [7:0] b);
      is_prefix = (b == `Y_SUBSTITUTE_PREFIX) || (b == `Y_INDIRECT_INDEXED_PREFIX)
         || (b == `INDIRECT_FORM_PREFIX);
   endfunction : is_prefix

   mode_t base;
   mode_t mode;
   logic y_sel;
   logic bad;

   // base mode from the opcode row
   always_comb begin
      case (opcode[7:4])
         4'h0: base = MODE_BIT_REL;
         4'h1: base = MODE_BIT_DIRECT;
         4'h2: base = MODE_REL_DIRECT;
         4'h3, 4'hb: base = MODE_DIR_SHORT;
         4'h6, 4'he: base = MODE_IDX_SHORT;
         4'h7, 4'hf: base = MODE_IDX_NONE;
         4'ha: base = (opcode == `RELATIVE_CALL_OPCODE) ? MODE_REL_DIRECT : MODE_IMMEDIATE;
         4'hc: base = MODE_DIR_LONG;
         4'hd: base = MODE_IDX_LONG;
         default: base = MODE_INHERENT;
      endcase
   end

   // prefix transforms; a disallowed pairing is flagged, never treated as illegal
   always_comb begin
      mode = base;
      y_sel = 1'b0;
      bad = 1'b0;
      if (has_prefix && is_prefix(opcode)) begin
         bad = 1'b1;
         mode = MODE_INHERENT;
      end else if (has_prefix && prefix == `Y_SUBSTITUTE_PREFIX) begin
         case (base)
            MODE_INHERENT, MODE_IMMEDIATE, MODE_DIR_SHORT, MODE_DIR_LONG,
            MODE_IDX_NONE, MODE_IDX_SHORT, MODE_IDX_LONG: y_sel = 1'b1;
            default: bad = 1'b1;
         endcase
      end else if (has_prefix && prefix == `INDIRECT_FORM_PREFIX) begin
         case (base)
            MODE_DIR_SHORT: mode = MODE_IND_SHORT;
            MODE_DIR_LONG: mode = MODE_IND_LONG;
            MODE_BIT_DIRECT: mode = MODE_IND_SHORT;
            MODE_BIT_REL: mode = MODE_BIT_REL_IND;
            MODE_REL_DIRECT: mode = MODE_REL_INDIRECT;
            MODE_IDX_SHORT: mode = MODE_IND_IDX_SHORT;
            MODE_IDX_LONG: mode = MODE_IND_IDX_LONG;
            default: bad = 1'b1;
         endcase
      end else if (has_prefix && prefix == `Y_INDIRECT_INDEXED_PREFIX) begin
         case (base)
            MODE_IDX_SHORT: begin
               mode = MODE_IND_IDX_SHORT;
               y_sel = 1'b1;
            end
            MODE_IDX_LONG: begin
               mode = MODE_IND_IDX_LONG;
               y_sel = 1'b1;
            end
            default: bad = 1'b1;
         endcase
      end
   end

   // byte counts per final mode
   always_comb begin
      dec.mode = mode;
      dec.use_y = y_sel;
      dec.combo_bad = bad;
      dec.legal = !is_undefined(opcode);
      dec.halt = (opcode == `HALT_OPCODE) && !bad;
      dec.wait_for_interrupt_op = (opcode == `WAIT_FOR_INTERRUPT_OPCODE) && !bad;
      dec.n_ptr = 2'd0;
      case (mode)
         MODE_INHERENT, MODE_IDX_NONE: dec.n_ops = 2'd0;
         MODE_DIR_LONG, MODE_IDX_LONG: dec.n_ops = 2'd2;
         MODE_BIT_REL, MODE_BIT_REL_IND: dec.n_ops = 2'd2;
         default: dec.n_ops = 2'd1;
      endcase
      case (mode)
         MODE_IND_SHORT, MODE_IND_IDX_SHORT: dec.n_ptr = 2'd1;
         MODE_IND_LONG, MODE_IND_IDX_LONG: dec.n_ptr = 2'd2;
         MODE_REL_INDIRECT, MODE_BIT_REL_IND: dec.n_ptr = 2'd1;
         default: dec.n_ptr = 2'd0;
      endcase
   end

endmodule : opcode_classifier
`default_nettype wire

//--- ea_unit.sv
// effective address and relative branch target computation
`timescale 1ns/1ps
`default_nettype none
`include "addr_decoder_cfg.svh"

module ea_unit
   import addr_decoder_pkg::*;
(
   input wire mode_t mode, // final addressing mode
   input wire logic use_y, // index Y instead of X
   input wire logic [7:0] x_val, // X index register
   input wire logic [7:0] y_val, // Y index register
   input wire logic [7:0] b1, // first byte after the opcode
   input wire logic [7:0] b2, // second byte after the opcode
   input wire logic [7:0] p0, // first pointer byte
   input wire logic [7:0] p1, // second pointer byte
   input wire logic [15:0] pc, // address of the following instruction
   output logic [15:0] ea, // operand address
   output logic [15:0] target // branch target
);

   // pc plus sign-extended byte offset
   function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] off);
      rel_target = base + {{8{off[7]}}, off};
   endfunction : rel_target

   // unsigned zero-extended index addition, no truncation
   function automatic logic [15:0] add_index(input logic [15:0] base, input logic [7:0] idx);
      add_index = base + {8'h00, idx};
   endfunction : add_index

   logic [7:0] idx;

   assign idx = use_y ? y_val : x_val;

   // address per mode; words are high byte first
   always_comb begin
      ea = 16'h0000;
      target = pc;
      case (mode)
         MODE_DIR_SHORT, MODE_BIT_DIRECT: ea = {`PAGE_ZERO_HI, b1};
         MODE_DIR_LONG: ea = {b1, b2};
         MODE_IDX_NONE: ea = {`PAGE_ZERO_HI, idx};
         MODE_IDX_SHORT: ea = add_index({`PAGE_ZERO_HI, b1}, idx);
         MODE_IDX_LONG: ea = add_index({b1, b2}, idx);
         MODE_IND_SHORT: ea = {`PAGE_ZERO_HI, p0};
         MODE_IND_LONG: ea = {p0, p1};
         MODE_IND_IDX_SHORT: ea = add_index({`PAGE_ZERO_HI, p0}, idx);
         MODE_IND_IDX_LONG: ea = add_index({p0, p1}, idx);
         MODE_REL_DIRECT: target = rel_target(pc, b1);
         MODE_REL_INDIRECT: target = rel_target(pc, p0);
         MODE_BIT_REL: begin
            ea = {`PAGE_ZERO_HI, b1};
            target = rel_target(pc, b2);
         end
         MODE_BIT_REL_IND: begin
            ea = {`PAGE_ZERO_HI, p0};
            target = rel_target(pc, b2);
         end
         default: ea = 16'h0000;
      endcase
   end

endmodule : ea_unit
`default_nettype wire

//--- decoder_props.sv
// concurrent checks on the decoder's top-level ports
`timescale 1ns/1ps
`default_nettype none
module decoder_props
   import addr_decoder_pkg::*;
(
   input wire logic REF_CLK, // core clock
   input wire logic RST_N, // async reset, active low
   input wire logic START, // decode request
   input wire logic [15:0] START_PC, // first byte address
   input wire logic [7:0] X_REG, // x index
   input wire logic [7:0] Y_REG, // y index
   input wire logic MEM_RD, // read request
   input wire logic [15:0] MEM_ADDR, // read address
   input wire logic [7:0] MEM_RDATA, // read data
   input wire logic MEM_ACK, // read data valid
   input wire logic BUSY, // decode running
   input wire logic DONE, // result valid
   input wire addr_decoder_pkg::result_t RESULT, // decoded instruction
   input wire logic [15:0] NEXT_PC, // following address
   input wire logic ILLEGAL_RST, // undefined code
   input wire logic HALT_REQ, // halt request
   input wire logic WAIT_REQ // wait request
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // handshake and completion
   done_ends_busy_a: assert property (DONE |-> !BUSY ##1 !DONE)
      else $error("busy or done held after done");
   read_in_busy_a: assert property (MEM_RD |-> BUSY ##1 !MEM_RD)
      else $error("read request outside decode or too long");
   length_range_a: assert property (DONE |-> RESULT.length inside {[3'h1:3'h4]})
      else $error("length out of range");
   // address relations, immediate length, power and illegal-code pulses
   rel_target_a: assert property (DONE && RESULT.mode == MODE_REL_DIRECT |->
      RESULT.target == NEXT_PC + {{8{RESULT.operand[7]}}, RESULT.operand})
      else $error("relative target wrong");
   idx_none_ea_a: assert property (DONE && RESULT.mode == MODE_IDX_NONE |->
      RESULT.ea == {8'h00, (RESULT.use_y ? Y_REG : X_REG)})
      else $error("no-offset indexed address wrong");
   idx_short_ea_a: assert property (DONE && RESULT.mode == MODE_IDX_SHORT |->
      RESULT.ea == {8'h00, (RESULT.use_y ? Y_REG : X_REG)} + {8'h00, RESULT.operand})
      else $error("short indexed address wrong");
   imm_length_a: assert property (DONE && RESULT.mode == MODE_IMMEDIATE &&
      !RESULT.use_y && !RESULT.combo_bad |-> RESULT.length == 3'h2)
      else $error("immediate length wrong");
   power_with_done_a: assert property ((HALT_REQ || WAIT_REQ) |->
      DONE && RESULT.length == 3'h1 && !(HALT_REQ && WAIT_REQ))
      else $error("power request without single-byte done");
   illegal_no_done_a: assert property (ILLEGAL_RST |-> !DONE && !BUSY ##1 !DONE)
      else $error("illegal code completed a decode");
   // main scenarios seen
   halt_c: cover property (HALT_REQ);
   illegal_c: cover property (ILLEGAL_RST);
   rel_c: cover property (DONE && RESULT.mode == MODE_REL_INDIRECT);
endmodule : decoder_props
`default_nettype wire

//--- mem_model.sv
// program and data memory answering one read at a time after a set latency
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input wire logic clk, // core clock
   input wire logic rst_n, // async reset, active low
   input wire logic mem_rd, // read request pulse
   input wire logic [15:0] mem_addr, // read address
   input wire logic [3:0] lat, // extra wait cycles
   output logic [7:0] mem_rdata, // read data
   output logic mem_ack // data valid pulse
);
   logic [7:0] mem [0:65535];
   logic [15:0] addr_q;
   logic [3:0] cnt;
   logic pend;
   // answer a request; data line toggles when no answer is given
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         pend <= 1'b0;
         cnt <= 4'h0;
         addr_q <= 16'h0000;
         mem_rdata <= 8'h5a;
      end else begin
         mem_ack <= 1'b0;
         if (mem_rd && lat == 4'h0) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr];
         end else if (mem_rd) begin
            pend <= 1'b1;
            cnt <= lat;
            addr_q <= mem_addr;
            mem_rdata <= ~mem_rdata;
         end else if (pend && cnt == 4'h1) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[addr_q];
            pend <= 1'b0;
         end else begin
            cnt <= cnt - 4'h1;
            mem_rdata <= ~mem_rdata;
         end
      end
   end
endmodule : mem_model
`default_nettype wire

//--- tb_cpu_addressing_mode_decoder.sv
// self-checking bench for the addressing-mode decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_cpu_addressing_mode_decoder
   import addr_decoder_pkg::*;
;
   logic clk = 0, rst_n = 0, start = 0, mem_rd, mem_ack, busy, done, illegal, halt, wait_for_interrupt_op;
   logic [15:0] start_pc = 16'h0000, mem_addr, next_pc, npc;
   logic [7:0] x_reg = 8'h00, y_reg = 8'h00, mem_rdata;
   logic [3:0] lat = 4'h0;
   logic hq, wq, il;
   result_t res, r;
   int err_count = 0, n_tests = 0, rd_cnt = 0, nrd;
   always #2.5 clk = ~clk;
   // count read requests of one decode
   always @(posedge clk) if (mem_rd === 1'b1) rd_cnt++;
   addr_mode_decoder dut_u (.REF_CLK(clk), .RST_N(rst_n), .START(start), .START_PC(start_pc),
      .X_REG(x_reg), .Y_REG(y_reg), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata),
      .MEM_ACK(mem_ack), .BUSY(busy), .DONE(done), .RESULT(res), .NEXT_PC(next_pc),
      .ILLEGAL_RST(illegal), .HALT_REQ(halt), .WAIT_REQ(wait_for_interrupt_op));
   mem_model mem_u (.clk(clk), .rst_n(rst_n), .mem_rd(mem_rd), .mem_addr(mem_addr), .lat(lat),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   task automatic ld4(input logic [15:0] a, input logic [31:0] w);
      mem_u.mem[a] = w[31:24];
      mem_u.mem[a + 16'h1] = w[23:16];
      mem_u.mem[a + 16'h2] = w[15:8];
      mem_u.mem[a + 16'h3] = w[7:0];
   endtask : ld4
   task automatic dec(input logic [15:0] pc, input logic [7:0] x, input logic [7:0] y);
      int k;
      @(negedge clk);
      x_reg = x;
      y_reg = y;
      start_pc = pc;
      start = 1;
      rd_cnt = 0;
      @(negedge clk);
      start = 0;
      for (k = 0; k < 80 && done !== 1'b1 && illegal !== 1'b1; k++) @(negedge clk);
      r = res;
      npc = next_pc;
      hq = halt;
      wq = wait_for_interrupt_op;
      il = illegal;
      nrd = rd_cnt;
      if (k == 80) begin err_count++; $display("MISMATCH t=%0t decode hung", $time); end
      @(negedge clk);
   endtask : dec
   task automatic t_basic();
      ld4(16'h0100, 32'h9d000000);
      dec(16'h0100, 8'h00, 8'h00);
      `CHK(r.length, 3'h1)
      `CHK(nrd, 1)
      `CHK(npc, 16'h0101)
      ld4(16'h0110, 32'ha6550000);
      dec(16'h0110, 8'h00, 8'h00);
      `CHK(r.mode, MODE_IMMEDIATE)
      `CHK(r.operand, 8'h55)
      `CHK(nrd, 2)
   endtask : t_basic
   task automatic t_direct();
      lat = 4'h3;
      ld4(16'h0120, 32'hb6100000);
      dec(16'h0120, 8'h00, 8'h00);
      `CHK(r.ea, 16'h0010)
      ld4(16'h0130, 32'hc6123400);
      dec(16'h0130, 8'h00, 8'h00);
      `CHK(r.ea, 16'h1234)
      `CHK(r.length, 3'h3)
      `CHK(nrd, 3)
      lat = 4'h0;
   endtask : t_direct
   task automatic t_indexed();
      ld4(16'h0140, 32'hf6000000);
      dec(16'h0140, 8'h80, 8'h00);
      `CHK(r.ea, 16'h0080)
      `CHK(nrd, 1)
      ld4(16'h0150, 32'he6ff0000);
      dec(16'h0150, 8'hff, 8'h00);
      `CHK(r.ea, 16'h01fe)
      ld4(16'h0160, 32'hd6120000);
      dec(16'h0160, 8'h34, 8'h00);
      `CHK(r.ea, 16'h1234)
      `CHK(nrd, 3)
   endtask : t_indexed
   task automatic t_prefix();
      ld4(16'h0170, 32'h90e60100);
      dec(16'h0170, 8'h77, 8'h10);
      `CHK(r.use_y, 1'b1)
      `CHK(r.ea, 16'h0011)
      ld4(16'h0180, 32'h90d61200);
      dec(16'h0180, 8'h77, 8'h34);
      `CHK(r.length, 3'h4)
      `CHK(r.ea, 16'h1234)
   endtask : t_prefix
   task automatic t_indirect();
      ld4(16'h0020, 32'h44000000);
      ld4(16'h0040, 32'habcd0000);
      ld4(16'h0050, 32'hf8000000);
      ld4(16'h0190, 32'h92b62000);
      dec(16'h0190, 8'h00, 8'h00);
      `CHK(r.mode, MODE_IND_SHORT)
      `CHK(r.ea, 16'h0044)
      `CHK(nrd, 4)
      ld4(16'h01a0, 32'h92c64000);
      dec(16'h01a0, 8'h00, 8'h00);
      `CHK(r.ea, 16'habcd)
      `CHK(r.length, 3'h3)
      ld4(16'h01b0, 32'h92e65000);
      dec(16'h01b0, 8'h10, 8'h00);
      `CHK(r.mode, MODE_IND_IDX_SHORT)
      `CHK(r.ea, 16'h0108)
      ld4(16'h01c0, 32'h91e65000);
      dec(16'h01c0, 8'h00, 8'h10);
      `CHK(r.use_y, 1'b1)
      `CHK(r.ea, 16'h0108)
   endtask : t_indirect
   task automatic t_relative();
      ld4(16'h0200, 32'h27fe0000);
      dec(16'h0200, 8'h00, 8'h00);
      `CHK(r.target, 16'h0200)
      ld4(16'h0030, 32'h05000000);
      ld4(16'h0210, 32'h92273000);
      dec(16'h0210, 8'h00, 8'h00);
      `CHK(r.mode, MODE_REL_INDIRECT)
      `CHK(r.target, 16'h0218)
      ld4(16'h0220, 32'had800000);
      dec(16'h0220, 8'h00, 8'h00);
      `CHK(r.target, 16'h01a2)
      ld4(16'h0240, 32'h0310fd00);
      dec(16'h0240, 8'h00, 8'h00);
      `CHK(r.mode, MODE_BIT_REL)
      `CHK(r.ea, 16'h0010)
      `CHK(r.target, 16'h0240)
      ld4(16'h0250, 32'h920330fd);
      dec(16'h0250, 8'h00, 8'h00);
      `CHK(r.mode, MODE_BIT_REL_IND)
      `CHK(r.ea, 16'h0005)
      `CHK(r.target, 16'h0251)
      `CHK(nrd, 5)
   endtask : t_relative
   task automatic t_special();
      ld4(16'h0230, 32'h8e8f0000);
      dec(16'h0230, 8'h00, 8'h00);
      `CHK(hq, 1'b1)
      dec(16'h0231, 8'h00, 8'h00);
      `CHK(wq, 1'b1)
      ld4(16'h0300, 32'h31000000);
      dec(16'h0300, 8'h00, 8'h00);
      `CHK(il, 1'b1)
      ld4(16'h0310, 32'h90910000);
      dec(16'h0310, 8'h00, 8'h00);
      `CHK(il, 1'b0)
      `CHK(r.combo_bad, 1'b1)
   endtask : t_special
   task automatic give_verdict();
      if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // reset, then run the scenarios
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1;
      t_basic();
      t_direct();
      t_indexed();
      t_prefix();
      t_indirect();
      t_relative();
      t_special();
      give_verdict();
   end
   // cut a hang short
   initial begin
      #20000;
      err_count++;
      give_verdict();
   end
endmodule : tb_cpu_addressing_mode_decoder
bind addr_mode_decoder decoder_props chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .START(START),
   .START_PC(START_PC), .X_REG(X_REG), .Y_REG(Y_REG), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
   .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .BUSY(BUSY), .DONE(DONE), .RESULT(RESULT),
   .NEXT_PC(NEXT_PC), .ILLEGAL_RST(ILLEGAL_RST), .HALT_REQ(HALT_REQ), .WAIT_REQ(WAIT_REQ));
`default_nettype wire
